//--- design/cfd_bank.sv
`timescale 1ns/100ps
module cfd_bank
  import cfd_pkg::*;
#(
  parameter int unsigned NOUT = 2
) (
  // Shared core signals
  cfd_core_if.bank cif,
  // Divide select and clear
  input logic div_sel_lo_i,
  input logic div_sel_hi_i,
  input logic master_clear_n_i,
  // Differential outputs
  output logic [NOUT-1:0] q_o,
  output logic [NOUT-1:0] qn_o
);
  cfd_mode_t mode;
  cfd_mode_t next_mode;
  logic next_q;
  logic q;
  logic [1:0] cnt_next;

  always_comb begin
    if (div_sel_hi_i) begin
      next_mode = CFD_DIV4;
    end else if (div_sel_lo_i) begin
      next_mode = CFD_DIV2;
    end else begin
      next_mode = CFD_PASS;
    end
  end

  // Ratio changes only at the common wrap or while run is low, so no runt
  always_ff @(posedge cif.clk or negedge cif.rst_n) begin
    if (!cif.rst_n) begin
      mode <= CFD_DIV4;
    end else if (!cif.run || (cif.tick && cif.cnt == CNT_WRAP)) begin
      mode <= next_mode;
    end
  end

  // Dividers use the count this edge loads, so they rise with the pass path
  assign cnt_next = cif.tick ? cif.cnt + CNT_ONE : cif.cnt;

  always_comb begin
    unique case (mode)
      CFD_PASS: next_q = cif.level;
      CFD_DIV2: next_q = cnt_next[0];
      CFD_DIV4: next_q = (cnt_next == CNT_ONE) || (cnt_next == CNT_TWO);
      default: next_q = 1'b0;
    endcase
  end

  always_ff @(posedge cif.clk or negedge cif.rst_n) begin
    if (!cif.rst_n) begin
      q <= 1'b0;
    end else begin
      q <= next_q & cif.run & cif.alive;
    end
  end

  // Pin clear overrides the flop without any clock
  assign q_o = {NOUT{q & master_clear_n_i}};
  assign qn_o = ~q_o;

endmodule // cfd_bank

//--- design/cfd_core_if.sv
`timescale 1ns/100ps
interface cfd_core_if (
  input logic clk
);
  logic rst_n;
  logic level;
  logic tick;
  logic alive;
  logic [1:0] cnt;
  logic run;

  modport stage (input clk, rst_n, output level, tick, alive);
  modport core (input clk, level, tick, alive, output rst_n, cnt, run);
  modport bank (input clk, rst_n, level, tick, alive, cnt, run);
endinterface

//--- design/cfd_fanout.sv
`timescale 1ns/100ps
// ==========================================================
// Clock fanout with four divider banks
// ==========================================================
// Operation
// - A low master clear forces true outputs low and complements high with no clock.
// - Outputs stay cleared while master clear is low and free only once it is high.
// - After clear release four input clock edges pass, then all banks start together.
// - Four banks each pick pass, divide-by-two or divide-by-four and stay in phase.
// - Fifteen differential outputs in all are fed from the chosen input clock.
// - Each bank takes its ratio from its own pair of select bits.
// - Divide select bits default high when nobody sets them.
// - The choose control picks one of two inputs and defaults high.
// - Master clear acts only when low; an idle high line lets the outputs run.
// - A dead chosen input keeps every output quiet instead of toggling.
// - Output enable falling forces outputs low 2 to 5 input clocks later.
// - Output enable rising restarts outputs in step 3 to 6 input clocks later.
// - Output enable defaults high.
module cfd_fanout
  import cfd_pkg::*;
(
  // Clock and reset
  input logic clk_i,
  input logic resetn_i,
  // AXI4-Lite write address
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read address
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Clock inputs and clear
  input logic clock_in_first_i,
  input logic clock_in_second_i,
  input logic master_clear_n_i,
  // Bank A outputs
  output logic [1:0] bank_a_q_o,
  output logic [1:0] bank_a_qn_o,
  // Bank B outputs
  output logic [2:0] bank_b_q_o,
  output logic [2:0] bank_b_qn_o,
  // Bank C outputs
  output logic [3:0] bank_c_q_o,
  output logic [3:0] bank_c_qn_o,
  // Bank D outputs
  output logic [5:0] bank_d_q_o,
  output logic [5:0] bank_d_qn_o
);

  // ==========================================================
  // Reset release and clear synchroniser
  logic rst_meta;
  logic rst_n;
  logic clr_meta;
  logic clr_sync;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Starts asserted so the banks never run before the pin is seen
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clr_meta <= 1'b0;
      clr_sync <= 1'b0;
    end else begin
      clr_meta <= master_clear_n_i;
      clr_sync <= clr_meta;
    end
  end

  // ==========================================================
  // Shared signals for the input stage and banks
  cfd_core_if cif (.clk(clk_i));

  assign cif.rst_n = rst_n;

  // ==========================================================
  // Software registers
  logic input_choose;
  logic out_enable;
  logic bank_a_div_sel_lo;
  logic bank_a_div_sel_hi;
  logic bank_b_div_sel_lo;
  logic bank_b_div_sel_hi;
  logic bank_c_div_sel_lo;
  logic bank_c_div_sel_hi;
  logic bank_d_div_sel_lo;
  logic bank_d_div_sel_hi;

  // ==========================================================
  // Write channel
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_hs;
  logic w_hs;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;

  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full & ~s_axi_bvalid;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign wr_go = (aw_full | aw_hs) & (w_full | w_hs);
  assign wr_addr = aw_full ? aw_addr : s_axi_awaddr;
  assign wr_data = w_full ? w_data : s_axi_wdata;
  assign wr_strb = w_full ? w_strb : s_axi_wstrb;
  assign wr_hit = (wr_addr == CTRL_OFS) || (wr_addr == DIVSEL_OFS);

  // Address and data may arrive in either order; each is held alone
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end else if (aw_hs) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wr_go) begin
      w_full <= 1'b0;
    end else if (w_hs) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reset values stand in for open inputs pulled high
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      input_choose <= CTRL_RST[CTRL_CHOOSE_BIT];
      out_enable <= CTRL_RST[CTRL_EN_BIT];
    end else if (wr_go && wr_strb[0] && wr_addr == CTRL_OFS) begin
      input_choose <= wr_data[CTRL_CHOOSE_BIT];
      out_enable <= wr_data[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {bank_d_div_sel_hi, bank_d_div_sel_lo,
       bank_c_div_sel_hi, bank_c_div_sel_lo,
       bank_b_div_sel_hi, bank_b_div_sel_lo,
       bank_a_div_sel_hi, bank_a_div_sel_lo} <= DIVSEL_RST;
    end else if (wr_go && wr_strb[0] && wr_addr == DIVSEL_OFS) begin
      {bank_d_div_sel_hi, bank_d_div_sel_lo,
       bank_c_div_sel_hi, bank_c_div_sel_lo,
       bank_b_div_sel_hi, bank_b_div_sel_lo,
       bank_a_div_sel_hi, bank_a_div_sel_lo} <= wr_data[7:0];
    end
  end

  // ==========================================================
  // Start sequence and common counter
  cfd_state_t state;
  logic [2:0] sync_cnt;
  logic [1:0] cnt;
  logic run;
  logic en_pipe;
  logic run_live;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_CLEAR;
      sync_cnt <= SYNC_ZERO;
    end else if (!clr_sync) begin
      state <= ST_CLEAR;
      sync_cnt <= SYNC_ZERO;
    end else begin
      unique case (state)
        ST_CLEAR: begin
          state <= ST_SYNC;
          sync_cnt <= SYNC_ZERO;
        end
        ST_SYNC: begin
          if (cif.tick) begin
            if (sync_cnt == SYNC_LAST) begin
              state <= ST_RUN;
            end
            sync_cnt <= sync_cnt + SYNC_ONE;
          end
        end
        ST_RUN: state <= ST_RUN;
      endcase
    end
  end

  // Every bank reads this one counter, which keeps them in phase
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= CNT_ZERO;
    end else if (state != ST_RUN) begin
      cnt <= CNT_ZERO;
    end else if (cif.tick) begin
      cnt <= cnt + CNT_ONE;
    end
  end

  // Enable is retimed to input edges and applied only at a wrap, so a
  // change lands 2 to 5 edges later; the start needs no wrap at all
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_pipe <= 1'b0;
      run <= 1'b0;
    end else if (state != ST_RUN) begin
      en_pipe <= out_enable;
      run <= en_pipe;
    end else if (cif.tick) begin
      en_pipe <= out_enable;
      if (cnt == CNT_WRAP) begin
        run <= en_pipe;
      end
    end
  end

  // First RUN edge counts 0 to 1, so every ratio begins with a rise
  always_comb begin
    cif.cnt = cnt;
    cif.run = run & (state == ST_RUN) & (cnt != CNT_ZERO || cif.tick || run_live);
  end

  // Keeps the banks going once the first counting edge has passed
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_live <= 1'b0;
    end else begin
      run_live <= cif.run;
    end
  end

  // ==========================================================
  // Read channel
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      CTRL_OFS: begin
        rd_word[CTRL_CHOOSE_BIT] = input_choose;
        rd_word[CTRL_EN_BIT] = out_enable;
      end
      DIVSEL_OFS: begin
        rd_word[7:0] = {bank_d_div_sel_hi, bank_d_div_sel_lo,
                        bank_c_div_sel_hi, bank_c_div_sel_lo,
                        bank_b_div_sel_hi, bank_b_div_sel_lo,
                        bank_a_div_sel_hi, bank_a_div_sel_lo};
      end
      STATUS_OFS: begin
        rd_word[5:0] = {cnt, cif.alive, clr_sync, run, state == ST_RUN};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Input stage and banks
  cfd_input_stage u_stage (
    .cif(cif),
    .clock_in_first_i(clock_in_first_i),
    .clock_in_second_i(clock_in_second_i),
    .input_choose_i(input_choose)
  );

  cfd_bank #(.NOUT(2)) u_bank_a (
    .cif(cif),
    .div_sel_lo_i(bank_a_div_sel_lo),
    .div_sel_hi_i(bank_a_div_sel_hi),
    .master_clear_n_i(master_clear_n_i),
    .q_o(bank_a_q_o),
    .qn_o(bank_a_qn_o)
  );

  cfd_bank #(.NOUT(3)) u_bank_b (
    .cif(cif),
    .div_sel_lo_i(bank_b_div_sel_lo),
    .div_sel_hi_i(bank_b_div_sel_hi),
    .master_clear_n_i(master_clear_n_i),
    .q_o(bank_b_q_o),
    .qn_o(bank_b_qn_o)
  );

  cfd_bank #(.NOUT(4)) u_bank_c (
    .cif(cif),
    .div_sel_lo_i(bank_c_div_sel_lo),
    .div_sel_hi_i(bank_c_div_sel_hi),
    .master_clear_n_i(master_clear_n_i),
    .q_o(bank_c_q_o),
    .qn_o(bank_c_qn_o)
  );

  cfd_bank #(.NOUT(6)) u_bank_d (
    .cif(cif),
    .div_sel_lo_i(bank_d_div_sel_lo),
    .div_sel_hi_i(bank_d_div_sel_hi),
    .master_clear_n_i(master_clear_n_i),
    .q_o(bank_d_q_o),
    .qn_o(bank_d_qn_o)
  );

endmodule // cfd_fanout

//--- design/cfd_input_stage.sv
`timescale 1ns/100ps
module cfd_input_stage
  import cfd_pkg::*;
(
  // Shared core signals
  cfd_core_if.stage cif,
  // Clock inputs and choice
  input logic clock_in_first_i,
  input logic clock_in_second_i,
  input logic input_choose_i
);
  logic first_q;
  logic second_q;
  logic level_q;
  logic level_d;
  logic [FS_CW-1:0] idle_cnt;

  // ==========================================================
  // Sampling and 2:1 choice
  always_ff @(posedge cif.clk or negedge cif.rst_n) begin
    if (!cif.rst_n) begin
      first_q <= 1'b0;
      second_q <= 1'b0;
      level_q <= 1'b0;
      level_d <= 1'b0;
    end else begin
      first_q <= clock_in_first_i;
      second_q <= clock_in_second_i;
      level_q <= input_choose_i ? second_q : first_q;
      level_d <= level_q;
    end
  end

  assign cif.level = level_q;
  assign cif.tick = level_q & ~level_d;

  // ==========================================================
  // Fail-safe: a quiet or stuck input silences every bank
  always_ff @(posedge cif.clk or negedge cif.rst_n) begin
    if (!cif.rst_n) begin
      idle_cnt <= FS_LIMIT;
    end else if (cif.tick) begin
      idle_cnt <= FS_ZERO;
    end else if (idle_cnt != FS_LIMIT) begin
      idle_cnt <= idle_cnt + FS_ONE;
    end
  end

  assign cif.alive = (idle_cnt != FS_LIMIT);

endmodule // cfd_input_stage

//--- design/cfd_pkg.sv
package cfd_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Longest quiet spell of the chosen input before it counts as dead
  localparam int unsigned FS_TIME_NS = 640;
  localparam int unsigned FS_CYCLES = FS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned FS_CW = 8;
  localparam logic [FS_CW-1:0] FS_LIMIT = FS_CW'(FS_CYCLES);
  localparam logic [FS_CW-1:0] FS_ZERO = 8'h00;
  localparam logic [FS_CW-1:0] FS_ONE = 8'h01;
  localparam logic [2:0] SYNC_LAST = 3'h3;
  localparam logic [2:0] SYNC_ZERO = 3'h0;
  localparam logic [2:0] SYNC_ONE = 3'h1;

  // ==========================================================
  // Common phase counter
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_TWO = 2'h2;
  localparam logic [1:0] CNT_WRAP = 2'h3;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] DIVSEL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam int unsigned CTRL_CHOOSE_BIT = 0;
  localparam int unsigned CTRL_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [7:0] DIVSEL_RST = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CFD_PASS, CFD_DIV2, CFD_DIV4} cfd_mode_t;
  typedef enum logic [1:0] {ST_CLEAR, ST_SYNC, ST_RUN} cfd_state_t;

endpackage

//--- dv/cfd_clk_src.sv
`timescale 1ns/100ps
// ==========================================================
// Source of the two input clocks; run_i low freezes both levels
module cfd_clk_src #(
  parameter int HALF_A = 4,
  parameter int HALF_B = 6
) (
  // Reference
  input logic clk_i,
  input logic run_i,
  // Clocks
  output logic clk_a_o,
  output logic clk_b_o
);
  int ca = 0;
  int cb = 0;
  initial begin
    clk_a_o = 1'b0;
    clk_b_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (run_i) begin
      ca <= (ca == HALF_A - 1) ? 0 : ca + 1;
      cb <= (cb == HALF_B - 1) ? 0 : cb + 1;
      if (ca == HALF_A - 1) clk_a_o <= ~clk_a_o;
      if (cb == HALF_B - 1) clk_b_o <= ~clk_b_o;
    end
  end
endmodule // cfd_clk_src

//--- dv/cfd_fanout_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker
module cfd_fanout_chk (
  // Clock, reset and clear
  input logic clk_i,
  input logic resetn_i,
  input logic master_clear_n_i,
  input logic clock_in_first_i,
  input logic clock_in_second_i,
  // Bus handshake
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic s_axi_arready,
  // Bank outputs
  input logic [1:0] bank_a_q_o,
  input logic [1:0] bank_a_qn_o,
  input logic [2:0] bank_b_q_o,
  input logic [2:0] bank_b_qn_o,
  input logic [3:0] bank_c_q_o,
  input logic [3:0] bank_c_qn_o,
  input logic [5:0] bank_d_q_o,
  input logic [5:0] bank_d_qn_o
);
  logic [14:0] q;
  logic [14:0] qn;
  logic [7:0] quiet;
  assign q = {bank_d_q_o, bank_c_q_o, bank_b_q_o, bank_a_q_o};
  assign qn = {bank_d_qn_o, bank_c_qn_o, bank_b_qn_o, bank_a_qn_o};
  // Cycles with both inputs frozen; watching both avoids needing the choice
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quiet <= 8'h00;
    end else if (!$stable({clock_in_first_i, clock_in_second_i})) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  clear_forces_a: assert property (!master_clear_n_i |-> q == 15'h0000 && qn == 15'h7FFF)
    else $error("outputs not cleared while clear is low");
  clear_holds_a: assert property ($rose(master_clear_n_i) |-> (q == 15'h0000)[*4])
    else $error("outputs left clear too soon");
  diff_pair_a: assert property (qn == ~q)
    else $error("complement output does not mirror true output");
  bank_uniform_a: assert property (bank_a_q_o inside {2'h0, 2'h3} &&
    bank_b_q_o inside {3'h0, 3'h7} && bank_c_q_o inside {4'h0, 4'hF} &&
    bank_d_q_o inside {6'h00, 6'h3F}) else $error("outputs within a bank disagree");
  failsafe_quiet_a: assert property (quiet > 8'h48 |-> q == 15'h0000)
    else $error("outputs active with frozen inputs");
  bvalid_drop_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped before acceptance");
  rvalid_drop_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped before acceptance");
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  cover property ($fell(master_clear_n_i));
  cover property (quiet == 8'h49);
  cover property ($rose(bank_a_q_o[0]) && bank_d_q_o[0]);
endmodule // cfd_fanout_chk

bind cfd_fanout cfd_fanout_chk chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .master_clear_n_i(master_clear_n_i),
  .clock_in_first_i(clock_in_first_i), .clock_in_second_i(clock_in_second_i),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready),
  .bank_a_q_o(bank_a_q_o), .bank_a_qn_o(bank_a_qn_o), .bank_b_q_o(bank_b_q_o),
  .bank_b_qn_o(bank_b_qn_o), .bank_c_q_o(bank_c_q_o), .bank_c_qn_o(bank_c_qn_o),
  .bank_d_q_o(bank_d_q_o), .bank_d_qn_o(bank_d_qn_o)
);

//--- dv/clock_fanout_divider_banks_test.sv
`timescale 1ns/100ps
module clock_fanout_divider_banks_test
  import cfd_pkg::*;
();
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mcn = 1'b1;
  logic run = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, in_a, in_b;
  logic [1:0] bresp, rresp, qa, qna;
  logic [31:0] rdata;
  logic [2:0] qb, qnb;
  logic [3:0] qc, qnc;
  logic [5:0] qd, qnd;
  logic [14:0] q, qn;
  logic [7:0] ds = 8'hFF;
  logic [5:0] mon, mon_d = 6'h00;
  int rc [6] = '{default: 0};
  int dv [4] = '{1, 2, 4, 4};
  int error_cnt = 0;
  int samples_checked = 0;
  assign q = {qd, qc, qb, qa};
  assign qn = {qnd, qnc, qnb, qna};
  assign mon = {in_b, in_a, qd[0], qc[0], qb[0], qa[0]};

  cfd_clk_src #(.HALF_A(4), .HALF_B(6)) src (.clk_i(clk_i), .run_i(run), .clk_a_o(in_a),
    .clk_b_o(in_b));
  cfd_fanout dut (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clock_in_first_i(in_a),
    .clock_in_second_i(in_b), .master_clear_n_i(mcn), .bank_a_q_o(qa), .bank_a_qn_o(qna),
    .bank_b_q_o(qb), .bank_b_qn_o(qnb), .bank_c_q_o(qc), .bank_c_qn_o(qnc),
    .bank_d_q_o(qd), .bank_d_qn_o(qnd));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Rise counters, all sampled at the same edge so windows stay exact
  always @(posedge clk_i) begin
    mon_d <= mon;
    for (int i = 0; i < 6; i++) begin
      if (mon[i] && !mon_d[i]) rc[i] <= rc[i] + 1;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit bd;
    bd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bd = 1;
        bready <= 1'b0;
        check(32'(bresp), 32'(r));
      end
    end
    check(32'(bd), 32'h1);
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit got;
    got = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1;
        rready <= 1'b0;
        check(rdata, d);
        check(32'(rresp), 32'(r));
      end
    end
    check(32'(got), 32'h1);
    @(posedge clk_i);
  endtask
  // Bank rises seen while n rises of input s pass
  task automatic span(input int n, input int s, output int d [4]);
    int b [6];
    b = rc;
    for (int k = 0; k < 4000 && rc[4 + s] - b[4 + s] < n; k++) @(posedge clk_i);
    for (int i = 0; i < 4; i++) d[i] = rc[i] - b[i];
  endtask
  task automatic ratio(input int n, input int s);
    int d [4];
    span(n, s, d);
    for (int i = 0; i < 4; i++) check(d[i], n / dv[ds[2*i +: 2]]);
  endtask
  task automatic first_rise(output int n);
    int b;
    b = rc[4];
    for (int k = 0; k < 400 && !(mon[0] && !mon_d[0]); k++) @(posedge clk_i);
    n = rc[4] - b;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(CTRL_OFS, 32'h3, RESP_OKAY);
    rd(DIVSEL_OFS, 32'hFF, RESP_OKAY);
    rd(8'h0C, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask
  task automatic t_ratio();
    int d [4];
    for (int r = 0; r < 4; r++) begin
      ds = {2'(r + 3), 2'(r + 2), 2'(r + 1), 2'(r)};
      wr(DIVSEL_OFS, {24'h0, ds}, RESP_OKAY);
      rd(DIVSEL_OFS, {24'h0, ds}, RESP_OKAY);
      span(8, 1, d);
      ratio(16, 1);
    end
  endtask
  task automatic t_choose();
    int d [4];
    ds = 8'hE4;
    wr(DIVSEL_OFS, 32'hE4, RESP_OKAY);
    wr(CTRL_OFS, 32'h2, RESP_OKAY);
    span(8, 0, d);
    ratio(12, 0);
  endtask
  task automatic t_clear();
    int n;
    mcn <= 1'b0;
    #1;
    check(32'(q), 32'h0);
    check(32'(qn), 32'h7FFF);
    repeat (20) @(posedge clk_i);
    check(32'(q), 32'h0);
    mcn <= 1'b1;
    first_rise(n);
    check(32'(n >= 5 && n <= 6), 32'h1);
    check(32'(mon[3:0]), 32'hF);
  endtask
  task automatic t_enable();
    int d [4];
    int n;
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    span(2, 0, d);
    check(32'(d[0] > 0), 32'h1);
    span(6, 0, d);
    span(8, 0, d);
    check(32'(d[0] + d[1] + d[2] + d[3]), 32'h0);
    check(32'(qn), 32'h7FFF);
    wr(CTRL_OFS, 32'h2, RESP_OKAY);
    first_rise(n);
    check(32'(n >= 2 && n <= 6), 32'h1);
  endtask
  task automatic t_fail();
    int d [4];
    // Freeze while high: a plain pass path would then hold its outputs high
    for (int k = 0; k < 40 && !in_a; k++) @(posedge clk_i);
    run <= 1'b0;
    repeat (100) @(posedge clk_i);
    check(32'(q), 32'h0);
    run <= 1'b1;
    span(8, 0, d);
    ratio(12, 0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_ratio();
    t_choose();
    t_clear();
    t_enable();
    t_fail();
    conclude();
  end
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end
endmodule // clock_fanout_divider_banks_test
